/* hw/mmupw_pkg.sv */
// mmupw_pkg: constants, field positions, fault codes and carrier types for the page walker
// assumes a single 100 MHz system clock and a one-word read port to page-table memory
// Functional notes
// - level two type: fault, large, small, tiny
// - physical address upper bits from descriptor
// - four subpage fields; tiny has one
// - descriptor bits 3:2 give cache attributes
// - level one type 11 is fine table
// - table pointers trigger second memory read
// - differing subpage permissions load subpage only
// - alignment data-only; others need translation on
// - external abort only on waited accesses
// - violation suppresses bus access, aborts core
// - data abort records code, domain, address
// - priority alignment, translation, domain, permission, external
// - translation fault codes 0101 and 0111
// - domain fault codes 1001 and 1011
// - permission fault codes 1101 and 1111
// - external abort codes 1000 and 1010
// - domain field decode: none, client, manager
// - client permission values 01, 10, 11
// - permission 00 uses system and ROM bits
// - section permission checked before address out
// - level one type: fault, coarse, section, fine
// - first fetch: table base and address top
// - descriptor bits 8:5 select domain
package mmupw_pkg;
	localparam logic [1:0] DESC_FAULT = 2'h0;
	localparam logic [1:0] DESC_L1_COARSE = 2'h1;
	localparam logic [1:0] DESC_L1_SECTION = 2'h2;
	localparam logic [1:0] DESC_L1_FINE = 2'h3;
	localparam logic [1:0] DESC_L2_LARGE = 2'h1;
	localparam logic [1:0] DESC_L2_SMALL = 2'h2;
	localparam logic [1:0] DESC_L2_TINY = 2'h3;
	localparam logic [1:0] DOM_NONE = 2'h0;
	localparam logic [1:0] DOM_CLIENT = 2'h1;
	localparam logic [1:0] DOM_MANAGER = 2'h3;
	localparam logic [1:0] PERM_SPECIAL = 2'h0;
	localparam logic [1:0] PERM_SUPER = 2'h1;
	localparam logic [1:0] PERM_USER_RO = 2'h2;
	localparam logic [1:0] PERM_FULL = 2'h3;
	localparam int CTRL_SYSTEM_BIT = 8;
	localparam int CTRL_ROM_BIT = 9;
	localparam logic [3:0] FC_ALIGN = 4'h1;
	localparam logic [3:0] FC_TRANS_SECT = 4'h5;
	localparam logic [3:0] FC_TRANS_PAGE = 4'h7;
	localparam logic [3:0] FC_DOM_SECT = 4'h9;
	localparam logic [3:0] FC_DOM_PAGE = 4'hB;
	localparam logic [3:0] FC_PERM_SECT = 4'hD;
	localparam logic [3:0] FC_PERM_PAGE = 4'hF;
	localparam logic [3:0] FC_EXT_SECT = 4'h8;
	localparam logic [3:0] FC_EXT_PAGE = 4'hA;
	localparam logic [3:0] DOMAIN_INVALID = 4'h0;
	// page size codes reported with each translation
	localparam logic [2:0] SZ_SECTION = 3'h0;
	localparam logic [2:0] SZ_LARGE = 3'h1;
	localparam logic [2:0] SZ_LARGE_SUB = 3'h2;
	localparam logic [2:0] SZ_SMALL = 3'h3;
	localparam logic [2:0] SZ_SMALL_SUB = 3'h4;
	localparam logic [2:0] SZ_TINY = 3'h5;
	// access request from the core
	typedef struct packed {
		logic [31:0] modified_virtual_address;
		logic isData;
		logic isWrite;
		logic isUser;
		logic [1:0] accSize; // 0 byte, 1 halfword, 2 word
	} mmupw_req_t;
	// translation handed to the tlb and bus
	typedef struct packed {
		logic [31:0] physAddr;
		logic cacheable;
		logic bufferable;
		logic [2:0] entrySize;
		logic [3:0] domain;
		logic [1:0] perm;
	} mmupw_xlat_t;
endpackage : mmupw_pkg

/* hw/mmupw_perm_check.sv */
// mmupw_perm_check: combinational domain and permission verdict
// assumes domain field and permission value are already selected by the caller
`timescale 1ns/1ps
module mmupw_perm_check (
	input wire logic [1:0] domField,
	input wire logic [1:0] perm,
	input wire logic sysBit,
	input wire logic romBit,
	input wire logic isUser,
	input wire logic isWrite,
	output logic domFault,
	output logic permFault
);
	import mmupw_pkg::*;
	// domain then permission decode
	always_comb
	begin
		domFault = (domField != DOM_CLIENT) && (domField != DOM_MANAGER);
		permFault = 1'b0;
		if (domField == DOM_CLIENT)
		begin
			if (sysBit && romBit)
				permFault = 1'b1; // reserved pair faults every access
			else
			begin
				case (perm)
					PERM_SPECIAL: permFault = isWrite || (!sysBit && !romBit) ||
						(sysBit && isUser);
					PERM_SUPER: permFault = isUser;
					PERM_USER_RO: permFault = isUser && isWrite;
					PERM_FULL: permFault = 1'b0;
					default: permFault = 1'b1;
				endcase
			end
		end
	end
endmodule : mmupw_perm_check

/* hw/mmupw_l2_decode.sv */
// mmupw_l2_decode: decodes a level two descriptor into address, attributes and permission
// assumes the descriptor word is stable while the walker samples the outputs
`timescale 1ns/1ps
module mmupw_l2_decode (
	input wire logic [31:0] desc,
	input wire logic [31:0] modified_virtual_address,
	output logic invalid,
	output mmupw_pkg::mmupw_xlat_t xlat
);
	import mmupw_pkg::*;
	// page type, address and subpage selection
	always_comb
	begin
		logic [7:0] sub;
		logic [1:0] subIdx;
		logic same;
		sub = desc[11:4];
		subIdx = 2'h0;
		xlat = '0;
		xlat.cacheable = desc[3];
		xlat.bufferable = desc[2];
		same = (sub[1:0] == sub[3:2]) && (sub[3:2] == sub[5:4]) && (sub[5:4] == sub[7:6]);
		invalid = (desc[1:0] == DESC_FAULT);
		case (desc[1:0])
			DESC_L2_LARGE:
			begin
				xlat.physAddr = {desc[31:16], modified_virtual_address[15:0]};
				subIdx = modified_virtual_address[15:14];
				xlat.entrySize = same ? SZ_LARGE : SZ_LARGE_SUB;
			end
			DESC_L2_SMALL:
			begin
				xlat.physAddr = {desc[31:12], modified_virtual_address[11:0]};
				subIdx = modified_virtual_address[11:10];
				xlat.entrySize = same ? SZ_SMALL : SZ_SMALL_SUB;
			end
			DESC_L2_TINY:
			begin
				xlat.physAddr = {desc[31:10], modified_virtual_address[9:0]};
				xlat.entrySize = SZ_TINY;
			end
			default: xlat.entrySize = SZ_TINY;
		endcase
		if (desc[1:0] == DESC_L2_TINY)
			xlat.perm = desc[5:4];
		else
			xlat.perm = sub[{subIdx, 1'b0} +: 2];
	end
endmodule : mmupw_l2_decode

/* hw/mmupw_walker.sv */
// mmupw_walker: table walk, fault priority and fault recording for one access at a time
// assumes memory answers each read with memValid, and the bus reports extAbort per access
`timescale 1ns/1ps
module mmupw_walker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reqValid,
	input wire mmupw_pkg::mmupw_req_t req,
	input wire logic mmuEnable,
	input wire logic alignEnable,
	input wire logic [31:0] controlBits,
	input wire logic [31:0] tableBase,
	input wire logic [31:0] domainAccess,
	input wire logic [31:0] memData,
	input wire logic memValid,
	input wire logic busDone,
	input wire logic extAbort,
	output logic memRead_q,
	output logic [31:0] memAddr_q,
	output logic busStart_q,
	output mmupw_pkg::mmupw_xlat_t xlat_q,
	output logic done_q,
	output logic abort_q,
	output logic [3:0] faultCode_q,
	output logic [3:0] faultDomain_q,
	output logic [31:0] faultAddr_q
);
	import mmupw_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_L1 = 3'b001,
		ST_L2 = 3'b010,
		ST_BUS = 3'b011,
		ST_FIN = 3'b100
	} mmupw_state_t;
	mmupw_state_t state_q, state_d;
	mmupw_req_t req_q, req_d;
	logic [31:0] l1Desc_q, l1Desc_d;
	logic isPage_q, isPage_d;
	logic memRead_d, busStart_d, done_d, abort_d;
	logic [31:0] memAddr_d, faultAddr_d;
	logic [3:0] faultCode_d, faultDomain_d;
	mmupw_xlat_t xlat_d;
	logic misaligned, domFault, permFault, l2Invalid;
	logic [1:0] domField;
	mmupw_xlat_t l2Xlat;
	assign domField = domainAccess[{l1Desc_q[8:5], 1'b0} +: 2];
	mmupw_l2_decode uL2 (
		.desc(memData),
		.modified_virtual_address(req_q.modified_virtual_address),
		.invalid(l2Invalid),
		.xlat(l2Xlat)
	);
	mmupw_perm_check uPerm (
		.domField(domField),
		.perm(xlat_q.perm), // latched value; memData is not valid in the check state
		.sysBit(controlBits[CTRL_SYSTEM_BIT]),
		.romBit(controlBits[CTRL_ROM_BIT]),
		.isUser(req_q.isUser),
		.isWrite(req_q.isWrite),
		.domFault(domFault),
		.permFault(permFault)
	);
	assign misaligned = req_q.isData && alignEnable &&
		((req_q.accSize == 2'h2 && req_q.modified_virtual_address[1:0] != 2'h0) ||
		(req_q.accSize == 2'h1 && req_q.modified_virtual_address[0]));
	// walk sequencing, fault priority and recording
	always_comb
	begin
		state_d = state_q;
		req_d = req_q;
		l1Desc_d = l1Desc_q;
		isPage_d = isPage_q;
		memRead_d = 1'b0;
		memAddr_d = memAddr_q;
		busStart_d = 1'b0;
		done_d = 1'b0;
		abort_d = 1'b0;
		xlat_d = xlat_q;
		faultCode_d = faultCode_q;
		faultDomain_d = faultDomain_q;
		faultAddr_d = faultAddr_q;
		case (state_q)
			ST_IDLE:
			begin
				if (reqValid)
				begin
					req_d = req;
					isPage_d = 1'b0;
					state_d = ST_FIN;
					memAddr_d = {tableBase[31:14], req.modified_virtual_address[31:20], 2'h0};
					// read request stands from the cycle after the take
					memRead_d = mmuEnable;
					if (mmuEnable)
						state_d = ST_L1;
				end
			end
			ST_L1:
			begin
				memRead_d = !memValid;
				if (memValid)
				begin
					l1Desc_d = memData;
					case (memData[1:0])
						DESC_L1_SECTION:
						begin
							xlat_d.physAddr = {memData[31:20], req_q.modified_virtual_address[19:0]};
							xlat_d.cacheable = memData[3];
							xlat_d.bufferable = memData[2];
							xlat_d.entrySize = SZ_SECTION;
							xlat_d.domain = memData[8:5];
							xlat_d.perm = memData[11:10];
							state_d = ST_FIN;
						end
						DESC_L1_FINE:
						begin
							memAddr_d = {memData[31:12], req_q.modified_virtual_address[19:10], 2'h0};
							isPage_d = 1'b1;
							memRead_d = !misaligned;
							state_d = misaligned ? ST_FIN : ST_L2;
						end
						DESC_L1_COARSE:
						begin
							memAddr_d = {memData[31:10], req_q.modified_virtual_address[19:12], 2'h0};
							isPage_d = 1'b1;
							memRead_d = !misaligned;
							state_d = misaligned ? ST_FIN : ST_L2;
						end
						default: state_d = ST_FIN;
					endcase
				end
			end
			ST_L2:
			begin
				memRead_d = !memValid;
				if (memValid)
				begin
					xlat_d = l2Xlat;
					xlat_d.domain = l1Desc_q[8:5];
					l1Desc_d[31:10] = memData[31:10];
					l1Desc_d[1:0] = l2Invalid ? DESC_FAULT : DESC_L1_SECTION;
					state_d = ST_FIN;
				end
			end
			ST_FIN:
			begin
				abort_d = 1'b1;
				faultAddr_d = req_q.modified_virtual_address;
				faultDomain_d = l1Desc_q[8:5];
				if (misaligned)
				begin
					faultCode_d = FC_ALIGN;
					faultDomain_d = DOMAIN_INVALID;
				end
				else if (mmuEnable && l1Desc_q[1:0] == DESC_FAULT)
				begin
					faultCode_d = isPage_q ? FC_TRANS_PAGE : FC_TRANS_SECT;
					if (!isPage_q)
						faultDomain_d = DOMAIN_INVALID;
				end
				else if (mmuEnable && domFault)
					faultCode_d = isPage_q ? FC_DOM_PAGE : FC_DOM_SECT;
				else if (mmuEnable && permFault)
					faultCode_d = isPage_q ? FC_PERM_PAGE : FC_PERM_SECT;
				else
				begin
					abort_d = 1'b0;
					faultAddr_d = faultAddr_q;
					faultDomain_d = faultDomain_q;
					busStart_d = 1'b1;
					// flat access is treated as noncacheable so stale attributes never leak
					if (!mmuEnable)
					begin
						xlat_d.physAddr = req_q.modified_virtual_address;
						xlat_d.cacheable = 1'b0;
						xlat_d.bufferable = 1'b0;
					end
					state_d = ST_BUS;
				end
				if (abort_d)
				begin
					if (!req_q.isData)
					begin
						faultCode_d = faultCode_q;
						faultDomain_d = faultDomain_q;
						faultAddr_d = faultAddr_q;
					end
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_BUS:
			begin
				if (busDone)
				begin
					done_d = 1'b1;
					state_d = ST_IDLE;
					if (extAbort && !xlat_q.cacheable &&
						(!req_q.isWrite || !xlat_q.bufferable))
					begin
						abort_d = 1'b1;
						if (req_q.isData)
						begin
							faultCode_d = isPage_q ? FC_EXT_PAGE : FC_EXT_SECT;
							faultDomain_d = xlat_q.domain;
							faultAddr_d = req_q.modified_virtual_address;
						end
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end
	// state registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			req_q <= '0;
			l1Desc_q <= '0;
			isPage_q <= 1'b0;
			memRead_q <= 1'b0;
			memAddr_q <= '0;
			busStart_q <= 1'b0;
			xlat_q <= '0;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			faultCode_q <= '0;
			faultDomain_q <= '0;
			faultAddr_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			req_q <= req_d;
			l1Desc_q <= l1Desc_d;
			isPage_q <= isPage_d;
			memRead_q <= memRead_d;
			memAddr_q <= memAddr_d;
			busStart_q <= busStart_d;
			xlat_q <= xlat_d;
			done_q <= done_d;
			abort_q <= abort_d;
			faultCode_q <= faultCode_d;
			faultDomain_q <= faultDomain_d;
			faultAddr_q <= faultAddr_d;
		end
	end
endmodule : mmupw_walker

/* testbench/mmupw_mem_model.sv */
// mmupw_mem_model: table memory and external bus facing the walker
// assumes level one words below 0x4000, level two words above
`timescale 1ns/1ps
module mmupw_mem_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic memRead_q,
	input wire logic [31:0] memAddr_q,
	input wire logic busStart_q,
	input wire logic [31:0] l1,
	input wire logic [31:0] l2,
	input wire logic slow,
	input wire logic xAbt,
	output logic [31:0] memData,
	output logic memValid,
	output logic busDone,
	output logic extAbort
);
	import mmupw_pkg::*;
	logic go, mvD, bdD, busy_q, busy_d;
	logic [2:0] cnt_q, cnt_d;
	logic [31:0] word;
	// one word answers every replicated entry
	assign word = memAddr_q[14] ? l2 : l1;
	// idle data is inverted so stale words never match by luck
	assign memData = memValid ? word : ~word;
	// abort flag only counts with the done pulse
	assign extAbort = busDone ? xAbt : ~xAbt;
	// one latency count serves reads and bus accesses
	always_comb
	begin
		go = cnt_q >= (slow ? 3'h3 : 3'h0);
		mvD = memRead_q && !memValid && go;
		bdD = busy_q && go;
		busy_d = (busy_q && !bdD) || busStart_q;
		cnt_d = (mvD || bdD || !(memRead_q || busy_q)) ? 3'h0 : cnt_q + 3'h1;
	end
	// answer registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			{cnt_q, busy_q, memValid, busDone} <= '0;
		else
			{cnt_q, busy_q, memValid, busDone} <= {cnt_d, busy_d, mvD, bdD};
	end
endmodule : mmupw_mem_model

/* testbench/mmupw_assertions.sv */
// mmupw_checker: port relations of the walker
// assumes one access in flight and a steady table base
`timescale 1ns/1ps
module mmupw_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reqValid,
	input wire mmupw_pkg::mmupw_req_t req,
	input wire logic mmuEnable,
	input wire logic alignEnable,
	input wire logic [31:0] tableBase,
	input wire logic memValid,
	input wire logic busDone,
	input wire logic extAbort,
	input wire logic memRead_q,
	input wire logic [31:0] memAddr_q,
	input wire logic busStart_q,
	input wire mmupw_pkg::mmupw_xlat_t xlat_q,
	input wire logic done_q,
	input wire logic abort_q,
	input wire logic [3:0] faultCode_q
);
	import mmupw_pkg::*;
	logic take, mis, busy_q, busy_d, wr_q, wr_d, mis_q, mis_d;
	logic [31:0] va_q, va_d;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// keep the taken access, no port echoes it back
	always_comb
	begin
		take = reqValid && !busy_q;
		mis = req.isData && alignEnable;
		mis = mis && (req.accSize == 2'h2 ? |req.modified_virtual_address[1:0] : req.accSize == 2'h1 && req.modified_virtual_address[0]);
		busy_d = take || (busy_q && !done_q);
		wr_d = take ? req.isWrite : wr_q;
		mis_d = take ? mis : mis_q;
		va_d = take ? req.modified_virtual_address : va_q;
	end
	// helper registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			{busy_q, wr_q, mis_q, va_q} <= '0;
		else
			{busy_q, wr_q, mis_q, va_q} <= {busy_d, wr_d, mis_d, va_d};
	end
	sequence s_ext_abt;
		busDone && extAbort && !xlat_q.cacheable && (!xlat_q.bufferable || !wr_q);
	endsequence
	sequence s_ext_ign;
		busDone && xlat_q.cacheable;
	endsequence
	AST_L1_ADDR: assert property (take && mmuEnable |=> memRead_q &&
		memAddr_q == {tableBase[31:14], va_q[31:20], 2'h0}) else $error("bad first fetch");
	AST_READ_HOLD: assert property (memRead_q && !memValid |=> memRead_q && $stable(memAddr_q))
		else $error("table read dropped");
	AST_EXT_ABORT: assert property (s_ext_abt |=> done_q && abort_q)
		else $error("external abort lost");
	AST_EXT_IGNORE: assert property (s_ext_ign |=> done_q && !abort_q)
		else $error("cached access aborted");
	AST_ABORT_PULSE: assert property (abort_q |-> done_q ##1 !done_q)
		else $error("abort without done");
	AST_NO_BUS_ALIGN: assert property (busy_q && mis_q |-> !busStart_q)
		else $error("bus launched on fault");
	AST_ALIGN_CODE: assert property (done_q && mis_q |-> abort_q ##[0:1] faultCode_q == FC_ALIGN)
		else $error("alignment code wrong");
	AST_FLAT: assert property (busStart_q && !mmuEnable |-> xlat_q.physAddr == va_q)
		else $error("flat address wrong");
endmodule : mmupw_checker
bind mmupw_walker mmupw_checker u_chk (.clk_sys, .rst, .reqValid, .req, .mmuEnable,
	.alignEnable, .tableBase, .memValid, .busDone, .extAbort, .memRead_q, .memAddr_q,
	.busStart_q, .xlat_q, .done_q, .abort_q, .faultCode_q);

/* testbench/test_mmu_page_walk_fault_check.sv */
// test_mmu_page_walk_fault_check: directed walks, faults and aborts
// assumes the memory model answers table reads and bus launches
`timescale 1ns/1ps
module test_mmu_page_walk_fault_check;
	import mmupw_pkg::*;
	logic clk_sys = 0, rst = 1, reqValid = 0, mmuEn = 0, alnEn = 0, slow = 0, xAbt = 0;
	logic [31:0] ctl = '0, dac = '1, l1 = '0, l2 = '0, memData, memAddr_q, faultAddr_q, pa, l2a;
	logic memValid, busDone, extAbort, memRead_q, busStart_q, done_q, abort_q, ab, bs;
	logic [3:0] faultCode_q, faultDomain_q;
	mmupw_req_t req = '0;
	mmupw_xlat_t xlat_q;
	int fails = 0, check_count = 0, cyc = 0;
	mmupw_walker dut (.clk_sys, .rst, .reqValid, .req, .mmuEnable(mmuEn), .alignEnable(alnEn),
		.controlBits(ctl), .tableBase(32'h0), .domainAccess(dac), .memData, .memValid,
		.busDone, .extAbort, .memRead_q, .memAddr_q, .busStart_q, .xlat_q, .done_q,
		.abort_q, .faultCode_q, .faultDomain_q, .faultAddr_q);
	mmupw_mem_model mem (.clk_sys, .rst, .memRead_q, .memAddr_q, .busStart_q, .l1, .l2,
		.slow, .xAbt, .memData, .memValid, .busDone, .extAbort);
	// clock
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	// the run needs about 700 cycles, so this only catches hangs
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// f is {data, write, user, size}; ends one edge after done
	task automatic acc(input logic [31:0] va, input logic [4:0] f);
		req = {va, f};
		reqValid = 1;
		{bs, pa, l2a} = '0;
		@(negedge clk_sys);
		reqValid = 0;
		for (int n = 0; n < 60 && done_q !== 1'b1; n++)
		begin
			bs |= busStart_q;
			if (busStart_q)
				pa = xlat_q.physAddr;
			if (memRead_q && memAddr_q[14])
				l2a = memAddr_q;
			@(negedge clk_sys);
		end
		chk(done_q, 1'b1);
		ab = abort_q;
		@(negedge clk_sys);
	endtask : acc
	task automatic fc(input logic [3:0] c);
		chk(ab, 1'b1);
		chk(faultCode_q, c);
	endtask : fc
	task automatic flt(input logic [3:0] c, input logic [3:0] dm);
		fc(c);
		chk(bs, 1'b0);
		chk(faultDomain_q, dm);
		chk(faultAddr_q, req.modified_virtual_address);
	endtask : flt
	function automatic logic ok(input logic [1:0] ap, input logic s, r, u, w);
		if (s && r)
			return 1'b0;
		case (ap)
			2'h0: return r ? !w : (s && !u && !w);
			2'h1: return !u;
			2'h2: return !u || !w;
			default: return 1'b1;
		endcase
	endfunction : ok
	// section, then invalid level one and level two words
	task automatic t_sect;
		mmuEn = 1;
		l1 = 32'hABC00C72;
		acc(32'h00312345, 5'h12);
		chk(pa, 32'hABC12345);
		l1 = 32'h0;
		acc(32'h00312345, 5'h12);
		flt(FC_TRANS_SECT, DOMAIN_INVALID);
		l1 = 32'h0000C0B1;
		acc(32'h00312345, 5'h12);
		flt(FC_TRANS_PAGE, 4'h5);
	endtask : t_sect
	// page kinds through coarse and fine tables
	task automatic t_pages;
		logic [31:0] d1[4] = '{32'h0000C011, 32'h0000C013, 32'h0000C011, 32'h0000C013};
		logic [31:0] d2[4] = '{32'h12340FFD, 32'h12340E4D, 32'h87654E46, 32'hFEDCB43B};
		logic [2:0] sz[4] = '{SZ_LARGE, SZ_LARGE_SUB, SZ_SMALL_SUB, SZ_TINY};
		logic [31:0] e;
		for (int i = 0; i < 4; i++)
		begin
			l1 = d1[i];
			l2 = d2[i];
			acc(32'h00056789, 5'h12);
			case (l2[1:0])
				2'h1: e = {l2[31:16], 16'h6789};
				2'h2: e = {l2[31:12], 12'h789};
				default: e = {l2[31:10], 10'h389};
			endcase
			chk(pa, e);
			chk(l2a, l1[1] ? {l1[31:12], 10'h159, 2'h0} : {l1[31:10], 8'h56, 2'h0});
			chk(xlat_q.entrySize, sz[i]);
			chk({xlat_q.cacheable, xlat_q.bufferable}, l2[3:2]);
		end
	endtask : t_pages
	// domain fields 00 and 10 on a section and a page
	task automatic t_dom;
		l2 = 32'h87654FF6;
		for (int i = 0; i < 4; i++)
		begin
			dac = 32'hFFFFFFCF | (i[0] ? 32'h20 : 32'h0);
			l1 = i[1] ? 32'h0000C051 : 32'h00000052;
			acc(32'h00056789, 5'h12);
			flt(i[1] ? FC_DOM_PAGE : FC_DOM_SECT, 4'h2);
		end
		dac = 32'hFFFFFFDF;
	endtask : t_dom
	// every permission value, protect bits, mode and direction
	task automatic t_perm;
		logic [5:0] v;
		for (int i = 0; i < 64; i++)
		begin
			v = i[5:0];
			ctl = {22'h0, v[3:2], 8'h0};
			l1 = {20'h0, v[5:4], 10'h052};
			acc(32'h00056789, {1'b1, v[1], v[0], 2'h2});
			if (ok(v[5:4], v[2], v[3], v[0], v[1]))
				chk(ab, 1'b0);
			else
				flt(FC_PERM_SECT, 4'h2);
		end
		ctl = 32'h0;
		l1 = 32'h0000C051;
		l2 = 32'h87654E46;
		for (int k = 0; k < 4; k++)
		begin
			acc({20'h00056, k[1:0], 10'h0}, 5'h1E);
			if (k == 3)
				chk(ab, 1'b0);
			else
				flt(FC_PERM_PAGE, 4'h2);
		end
	endtask : t_perm
	// alignment with translation off and on
	task automatic t_align;
		mmuEn = 0;
		alnEn = 1;
		acc(32'h00000102, 5'h12);
		fc(FC_ALIGN);
		acc(32'h00000101, 5'h11);
		fc(FC_ALIGN);
		acc(32'h00000101, 5'h10);
		chk(pa, 32'h00000101);
		acc(32'h00000102, 5'h02);
		chk(ab, 1'b0);
		mmuEn = 1;
		l1 = 32'h0;
		acc(32'h00000102, 5'h12);
		fc(FC_ALIGN);
		alnEn = 0;
		acc(32'h00000102, 5'h12);
		fc(FC_TRANS_SECT);
		acc(32'h00400000, 5'h02);
		chk(ab, 1'b1);
		chk(faultAddr_q, 32'h00000102);
	endtask : t_align
	// external aborts on each attribute pair, slow answers
	task automatic t_ext;
		dac = '1;
		xAbt = 1;
		slow = 1;
		for (int i = 0; i < 8; i++)
		begin
			l1 = 32'h00000C12 | {28'h0, i[1:0], 2'h0};
			acc(32'h00056789, {1'b1, i[2], 3'h2});
			if (!i[1] && (!i[2] || !i[0]))
				fc(FC_EXT_SECT);
			else
				chk(ab, 1'b0);
		end
		l1 = 32'h0000C011;
		l2 = 32'h87654FF2;
		acc(32'h00056789, 5'h12);
		fc(FC_EXT_PAGE);
		xAbt = 0;
	endtask : t_ext
	task automatic final_report;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	// main sequence
	initial
	begin
		repeat (5) @(negedge clk_sys);
		rst = 0;
		t_sect();
		t_pages();
		t_dom();
		t_perm();
		t_align();
		t_ext();
		final_report();
	end
endmodule : test_mmu_page_walk_fault_check
